/* rtl/bsr_pkg.sv */
// Package: shared types and constants for the bit/skip/return executor
package bsr_pkg;
    // *********************************************
    // Opcodes (10-bit instruction words)
    // *********************************************
    localparam logic [9:0] OP_ROTATE = 10'h01d;
    localparam logic [9:0] OP_CARRY_CLR = 10'h006;
    localparam logic [9:0] OP_CARRY_SET = 10'h007;
    localparam logic [9:0] OP_PORTD_CLR = 10'h014;
    localparam logic [9:0] OP_PORTD_SET = 10'h015;
    localparam logic [9:0] OP_RET = 10'h044;
    localparam logic [9:0] OP_RET_SKIP = 10'h045;
    localparam logic [9:0] OP_RET_IRQ = 10'h046;
    localparam logic [9:0] OP_CMP_IMM = 10'h025;
    localparam logic [9:0] OP_CMP_MEM = 10'h026;
    localparam logic [9:0] OP_SKIP_EXT0 = 10'h038;
    localparam logic [9:0] OP_SKIP_CONV = 10'h287;
    localparam logic [9:0] OP_SKIP_PORTC = 10'h289;
    localparam logic [9:0] OP_SKIP_PIN = 10'h03a;
    localparam logic [9:0] OP_SKIP_PWRDN = 10'h003;
    localparam logic [9:0] OP_SKIP_TMR1 = 10'h280;
    localparam logic [9:0] OP_SKIP_TMR2 = 10'h281;
    localparam logic [9:0] OP_PORTC_CLR = 10'h28c;
    localparam logic [9:0] OP_PORTC_SET = 10'h28d;
    // Families with 2-bit immediate in bits 1:0
    localparam logic [7:0] OPF_BIT_CLR = 8'h13;
    localparam logic [7:0] OPF_BIT_SET = 8'h17;
    localparam logic [7:0] OPF_BIT_TEST = 8'h08;
    // Second word of compare-immediate: 0x070 + n
    localparam logic [5:0] OPF_CMP_WORD2 = 6'h07;
    // *********************************************
    // Sizes, bit positions, reset values
    // *********************************************
    localparam int PC_W = 12;
    localparam int STK_DEPTH = 8;
    localparam int STK_W = 3;
    localparam int RAM_AW = 8;
    localparam logic [3:0] PORTD_MAX = 4'h5;
    localparam int EXT0_EN_BIT = 0;
    localparam int TMR1_EN_BIT = 2;
    localparam int TMR2_EN_BIT = 3;
    localparam int CONV_EN_BIT = 2;
    localparam int PIN_SEL_BIT = 2;
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [5:0] PORTD_RST = 6'h00;

    // Context saved at interrupt entry, restored by interrupt return
    typedef struct packed {
        logic [3:0] ptrX;
        logic [3:0] ptrY;
        logic [1:0] ptrZ;
        logic carry;
        logic skip;
        logic loadSup;
        logic [3:0] accA;
        logic [3:0] regB;
    } bsr_ctx_s;

    // Request flags cleared by the skip instructions
    typedef struct packed {
        logic ext0;
        logic conv;
        logic tmr1;
        logic tmr2;
    } bsr_flags_s;
endpackage

/* rtl/bsr_ram.sv */
// Memory: data RAM nibbles with registered read port
`timescale 1ns/1ps
module bsr_ram (
    // Clock
    input wire logic clock,
    // Write port
    input wire logic wrEn,
    input wire logic [bsr_pkg::RAM_AW-1:0] wrAddr,
    input wire logic [3:0] wrData,
    // Read port
    input wire logic [bsr_pkg::RAM_AW-1:0] rdAddr,
    output logic [3:0] rdData
);
    import bsr_pkg::*;
    logic [3:0] mem [0:(1<<RAM_AW)-1]; // Nibble store, no reset by design

    // Single clocked process: write and registered read
    always_ff @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

/* rtl/bsr_exec.sv */
// Executor for rotate, bit set/clear, returns and skip instructions
// Notes on behaviour
// - Rotate right accumulator through carry
// - Bit clear/set RAM nibble at pointer
// - Carry set: one carry, one cycle
// - Port D bit Y cleared
// - Y above five: port D untouched
// - Return: two cycles, pop counter, decrement
// - Interrupt return restores counter and context
// - Return-and-skip skips instruction at return
// - Compare immediate: two words, skip equal
// - External flag skip, clear, unless enabled
// - Conversion flag skip, clear, unless enabled
// - Pin level skip, polarity by select
// - Power-down flag skip, flag untouched
// - Timer1 flag skip, clear, unless enabled
// - Timer2 flag skip, clear, unless enabled
`timescale 1ns/1ps
module bsr_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Instruction stream, one word per cycle when fetchReady
    input wire logic [9:0] instr,
    input wire logic instrValid,
    // Stack push from call logic and interrupt entry context
    input wire logic stackPush,
    input wire logic [bsr_pkg::PC_W-1:0] pushPc,
    input wire logic ctxSave,
    input wire bsr_pkg::bsr_ctx_s ctxIn,
    // Enable and select bits
    input wire logic [3:0] irqCtrl1,
    input wire logic [3:0] irqCtrl2,
    input wire logic [3:0] intCtrl1,
    // Event flag sets from peripherals
    input wire bsr_pkg::bsr_flags_s flagSet,
    input wire logic powerDown,
    // Pins, synchronised internally
    input wire logic irqPin,
    input wire logic portCIn,
    // Outputs
    output logic fetchReady_ff,
    output logic [bsr_pkg::PC_W-1:0] pc_ff,
    output logic [bsr_pkg::STK_W-1:0] stackLevel_ff,
    output bsr_pkg::bsr_ctx_s state_ff,
    output bsr_pkg::bsr_flags_s flags_ff,
    output logic [5:0] portD_ff,
    output logic portC_ff
);
    import bsr_pkg::*;

    // *********************************************
    // Sequencer
    // *********************************************
    typedef enum {S_FETCH, S_READ, S_RET2, S_CMP2} bsr_state_e;
    bsr_state_e st_ff, nxt_st;          // Multi-cycle sequencing
    logic [9:0] op_ff, nxt_op;          // Latched opcode across extra cycles
    logic retSkip_ff, nxt_retSkip;      // Return-and-skip pending
    logic [PC_W-1:0] returnStack [0:STK_DEPTH-1]; // Return addresses
    logic [PC_W-1:0] nxt_pc;
    logic [STK_W-1:0] nxt_stackLevel;
    bsr_ctx_s nxt_state, saved_ff, nxt_saved;
    bsr_flags_s nxt_flags;
    logic [5:0] nxt_portD;
    logic nxt_portC, nxt_fetchReady;
    logic [1:0] pinSync_ff, cSync_ff;   // Two-stage pin synchronisers
    logic [3:0] ramRd;                  // Nibble at data pointer
    logic ramWe;
    logic [3:0] ramWd;
    logic doSkip;                       // Skip decision of current op
    logic [RAM_AW-1:0] dpAddr;

    assign dpAddr = {state_ff.ptrX, state_ff.ptrY};

    // RAM reads take a cycle, so memory ops use S_READ
    bsr_ram ramInst (
        .clock(clock),
        .wrEn(ramWe),
        .wrAddr(dpAddr),
        .wrData(ramWd),
        .rdAddr(dpAddr),
        .rdData(ramRd)
    );

    // Pin synchronisers: stage 0 only feeds stage 1
    always_ff @(posedge clock) begin
        pinSync_ff <= {pinSync_ff[0], irqPin};
        cSync_ff <= {cSync_ff[0], portCIn};
    end

    // Next-state computation for the whole executor
    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_retSkip = retSkip_ff;
        nxt_pc = pc_ff;
        nxt_stackLevel = stackLevel_ff;
        nxt_state = state_ff;
        nxt_saved = saved_ff;
        nxt_flags = flags_ff;
        nxt_portD = portD_ff;
        nxt_portC = portC_ff;
        nxt_fetchReady = 1'b1;
        ramWe = 1'b0;
        ramWd = ramRd;
        doSkip = 1'b0;
        if (ctxSave) begin
            nxt_saved = ctxIn;
        end
        case (st_ff)
            S_FETCH: begin
                if (instrValid && state_ff.skip) begin
                    // Skipped word consumed, skip state cleared
                    nxt_state.skip = 1'b0;
                    nxt_pc = pc_ff + 1'b1;
                end else if (instrValid) begin
                    nxt_op = instr;
                    nxt_pc = pc_ff + 1'b1;
                    if (instr == OP_ROTATE) begin
                        nxt_state.carry = state_ff.accA[0];
                        nxt_state.accA = {state_ff.carry, state_ff.accA[3:1]};
                    end else if (instr == OP_CARRY_CLR) begin
                        nxt_state.carry = 1'b0;
                    end else if (instr == OP_CARRY_SET) begin
                        nxt_state.carry = 1'b1;
                    end else if (instr == OP_PORTD_CLR || instr == OP_PORTD_SET) begin
                        if (state_ff.ptrY <= PORTD_MAX) begin
                            nxt_portD[state_ff.ptrY[2:0]] = instr[0];
                        end
                    end else if (instr == OP_PORTC_CLR || instr == OP_PORTC_SET) begin
                        nxt_portC = instr[0];
                    end else if (instr == OP_RET || instr == OP_RET_SKIP) begin
                        nxt_st = S_RET2;
                        nxt_retSkip = instr[0];
                        nxt_fetchReady = 1'b0;
                    end else if (instr == OP_RET_IRQ) begin
                        nxt_pc = returnStack[stackLevel_ff];
                        nxt_stackLevel = stackLevel_ff - 1'b1;
                        nxt_state = saved_ff;
                    end else if (instr == OP_CMP_IMM) begin
                        nxt_st = S_CMP2;
                    end else if (instr == OP_CMP_MEM || instr[9:2] == OPF_BIT_CLR
                                 || instr[9:2] == OPF_BIT_SET || instr[9:2] == OPF_BIT_TEST) begin
                        nxt_st = S_READ;
                        nxt_fetchReady = 1'b0;
                    end else if (instr == OP_SKIP_EXT0) begin
                        if (!irqCtrl1[EXT0_EN_BIT] && flags_ff.ext0) begin
                            doSkip = 1'b1;
                            nxt_flags.ext0 = 1'b0;
                        end
                    end else if (instr == OP_SKIP_CONV) begin
                        if (!irqCtrl2[CONV_EN_BIT] && flags_ff.conv) begin
                            doSkip = 1'b1;
                            nxt_flags.conv = 1'b0;
                        end
                    end else if (instr == OP_SKIP_TMR1) begin
                        if (!irqCtrl1[TMR1_EN_BIT] && flags_ff.tmr1) begin
                            doSkip = 1'b1;
                            nxt_flags.tmr1 = 1'b0;
                        end
                    end else if (instr == OP_SKIP_TMR2) begin
                        if (!irqCtrl1[TMR2_EN_BIT] && flags_ff.tmr2) begin
                            doSkip = 1'b1;
                            nxt_flags.tmr2 = 1'b0;
                        end
                    end else if (instr == OP_SKIP_PIN) begin
                        doSkip = (pinSync_ff[1] == intCtrl1[PIN_SEL_BIT]);
                    end else if (instr == OP_SKIP_PWRDN) begin
                        doSkip = powerDown;
                    end else if (instr == OP_SKIP_PORTC) begin
                        doSkip = cSync_ff[1];
                    end
                end
            end
            S_READ: begin
                // RAM nibble now valid for the latched op
                nxt_st = S_FETCH;
                if (op_ff == OP_CMP_MEM) begin
                    doSkip = (state_ff.accA == ramRd);
                end else if (op_ff[9:2] == OPF_BIT_TEST) begin
                    doSkip = !ramRd[op_ff[1:0]];
                end else begin
                    ramWe = 1'b1;
                    ramWd[op_ff[1:0]] = (op_ff[9:2] == OPF_BIT_SET);
                end
            end
            S_RET2: begin
                // Second cycle of a subroutine return
                nxt_st = S_FETCH;
                nxt_pc = returnStack[stackLevel_ff];
                nxt_stackLevel = stackLevel_ff - 1'b1;
                doSkip = retSkip_ff;
                nxt_retSkip = 1'b0;
            end
            S_CMP2: begin
                // Second word carries the immediate
                if (instrValid) begin
                    nxt_st = S_FETCH;
                    nxt_pc = pc_ff + 1'b1;
                    doSkip = (instr[9:4] == OPF_CMP_WORD2) && (instr[3:0] == state_ff.accA);
                end
            end
            default: begin
                nxt_st = S_FETCH;
            end
        endcase
        if (doSkip) begin
            nxt_state.skip = 1'b1;
        end
        // Peripheral sets win over instruction clears
        nxt_flags = nxt_flags | flagSet;
        if (stackPush) begin
            nxt_stackLevel = stackLevel_ff + 1'b1;
        end
    end

    // Registers of the executor
    always_ff @(posedge clock) begin
        if (srst) begin
            st_ff <= S_FETCH;
            op_ff <= 10'h000;
            retSkip_ff <= 1'b0;
            pc_ff <= PC_RST;
            stackLevel_ff <= '0;
            state_ff <= '0;
            saved_ff <= '0;
            flags_ff <= '0;
            portD_ff <= PORTD_RST;
            portC_ff <= 1'b0;
            fetchReady_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            retSkip_ff <= nxt_retSkip;
            pc_ff <= nxt_pc;
            stackLevel_ff <= nxt_stackLevel;
            state_ff <= nxt_state;
            saved_ff <= nxt_saved;
            flags_ff <= nxt_flags;
            portD_ff <= nxt_portD;
            portC_ff <= nxt_portC;
            fetchReady_ff <= nxt_fetchReady;
        end
    end

    // Stack storage, written on push at the new level
    always_ff @(posedge clock) begin
        if (stackPush) begin
            returnStack[stackLevel_ff + 1'b1] <= pushPc;
        end
    end

    // *********************************************
    // Assertions
    // *********************************************
    rotate_carry_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_ROTATE)
        |=> state_ff.carry == $past(state_ff.accA[0])) else $error("rotate carry wrong");
    carry_clear_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_CARRY_CLR)
        |=> !state_ff.carry) else $error("carry not cleared");
    carry_set_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_CARRY_SET)
        |=> state_ff.carry) else $error("carry not set");
    portd_range_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr[9:1] == OP_PORTD_CLR[9:1]
         && state_ff.ptrY > PORTD_MAX) |=> $stable(portD_ff)) else $error("port D changed");
    ret_two_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_RET && !stackPush)
        |=> ##1 stackLevel_ff == $past(stackLevel_ff, 2) - 1'b1) else $error("return level wrong");
    ret_skip_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_RET_SKIP)
        |=> ##1 state_ff.skip) else $error("return skip missing");
    ext0_skip_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_SKIP_EXT0
         && irqCtrl1[EXT0_EN_BIT]) |=> !state_ff.skip) else $error("ext0 skip while enabled");
    pwrdn_skip_a: assert property (@(posedge clock) disable iff (srst)
        (st_ff == S_FETCH && instrValid && !state_ff.skip && instr == OP_SKIP_PWRDN)
        |=> state_ff.skip == $past(powerDown)) else $error("power-down skip wrong");
    ret_cover_c: cover property (@(posedge clock) st_ff == S_RET2);
    cmp_cover_c: cover property (@(posedge clock) st_ff == S_CMP2 ##1 state_ff.skip);
    flag_cover_c: cover property (@(posedge clock) $fell(flags_ff.tmr1));
endmodule

/* sim/tb_top.sv */
// Self-checking testbench for the bit/skip/return executor
`timescale 1ns/1ps
module tb_top;
    import bsr_pkg::*;
    // ************************************
    // Case table: inputs beside expected outputs
    // ************************************
    typedef struct packed {
        logic [9:0] op;
        logic [3:0] a;
        logic c;
        logic [3:0] e1;
        logic [3:0] e2;
        logic [3:0] i1;
        logic [3:0] fs;
        logic pd;
        logic pin;
        logic pcIn;
        logic [3:0] xa;
        logic xc;
        logic xs;
        logic [3:0] xf;
    } bsr_row_s;
    localparam int NROW = 22;
    // Flag nibble order is ext0, conv, tmr1, tmr2 from the top bit down
    localparam bsr_row_s ROWS [NROW] = '{
        '{OP_ROTATE,4'h6,'1,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'hb,'0,'0,4'h0},
        '{OP_ROTATE,4'h9,'0,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h4,'1,'0,4'h0},
        '{OP_CARRY_CLR,4'h3,'1,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h3,'0,'0,4'h0},
        '{OP_CARRY_SET,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h3,'1,'0,4'h0},
        '{OP_SKIP_EXT0,4'h3,'0,4'h0,4'h0,4'h0,4'h8,'0,'0,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_EXT0,4'h3,'0,4'h1,4'h0,4'h0,4'h8,'0,'0,'0,4'h3,'0,'0,4'h8},
        '{OP_SKIP_EXT0,4'h3,'0,4'he,4'h0,4'h0,4'h0,'0,'0,'0,4'h3,'0,'0,4'h0},
        '{OP_SKIP_CONV,4'h3,'0,4'hf,4'h0,4'h0,4'h4,'0,'0,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_CONV,4'h3,'0,4'h0,4'h4,4'h0,4'h4,'0,'0,'0,4'h3,'0,'0,4'h4},
        '{OP_SKIP_TMR1,4'h3,'0,4'hb,4'h0,4'h0,4'h3,'0,'0,'0,4'h3,'0,'1,4'h1},
        '{OP_SKIP_TMR1,4'h3,'0,4'h4,4'h0,4'h0,4'h2,'0,'0,'0,4'h3,'0,'0,4'h2},
        '{OP_SKIP_TMR2,4'h3,'0,4'h7,4'h0,4'h0,4'h1,'0,'0,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_TMR2,4'h3,'0,4'h8,4'h0,4'h0,4'h1,'0,'0,'0,4'h3,'0,'0,4'h1},
        '{OP_SKIP_PIN,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_PIN,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'0,'1,'0,4'h3,'0,'0,4'h0},
        '{OP_SKIP_PIN,4'h3,'0,4'h0,4'h0,4'h4,4'h0,'0,'1,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_PIN,4'h3,'0,4'h0,4'h0,4'hb,4'h0,'0,'0,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_PWRDN,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'1,'0,'0,4'h3,'0,'1,4'h0},
        '{OP_SKIP_PWRDN,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h3,'0,'0,4'h0},
        '{OP_SKIP_PORTC,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'0,'0,'1,4'h3,'0,'1,4'h0},
        '{OP_SKIP_PORTC,4'h3,'0,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h3,'0,'0,4'h0},
        '{OP_ROTATE,4'h0,'1,4'h0,4'h0,4'h0,4'h0,'0,'0,'0,4'h8,'0,'0,4'h0}
    };
    // Port D steps: index, operation, expected port
    localparam logic [3:0] PD_Y [5] = '{4'h5, 4'h6, 4'hf, 4'h0, 4'h5};
    localparam logic [9:0] PD_OP [5] = '{OP_PORTD_SET, OP_PORTD_SET, OP_PORTD_CLR, OP_PORTD_SET, OP_PORTD_CLR};
    localparam logic [5:0] PD_EXP [5] = '{6'h20, 6'h20, 6'h20, 6'h21, 6'h01};
    // ************************************
    // Design signals
    // ************************************
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [9:0] instr = 10'h000;
    logic instrValid = 1'b0;
    logic stackPush = 1'b0;
    logic [PC_W-1:0] pushPc = 12'h000;
    logic ctxSave = 1'b0;
    bsr_ctx_s ctxIn = '0;
    logic [3:0] irqCtrl1 = 4'h0;
    logic [3:0] irqCtrl2 = 4'h0;
    logic [3:0] intCtrl1 = 4'h0;
    bsr_flags_s flagSet = '0;
    logic powerDown = 1'b0;
    logic irqPin = 1'b0;
    logic portCIn = 1'b0;
    logic fetchReady_ff;
    logic [PC_W-1:0] pc_ff;
    logic [STK_W-1:0] stackLevel_ff;
    bsr_ctx_s state_ff;
    bsr_flags_s flags_ff;
    logic [5:0] portD_ff;
    logic portC_ff;
    int num_errors = 0;
    int comparisons = 0;

    bsr_exec i_dut (.clock(clock), .srst(srst), .instr(instr), .instrValid(instrValid),
        .stackPush(stackPush), .pushPc(pushPc), .ctxSave(ctxSave), .ctxIn(ctxIn),
        .irqCtrl1(irqCtrl1), .irqCtrl2(irqCtrl2), .intCtrl1(intCtrl1), .flagSet(flagSet),
        .powerDown(powerDown), .irqPin(irqPin), .portCIn(portCIn), .fetchReady_ff(fetchReady_ff),
        .pc_ff(pc_ff), .stackLevel_ff(stackLevel_ff), .state_ff(state_ff), .flags_ff(flags_ff),
        .portD_ff(portD_ff), .portC_ff(portC_ff));

    // 25 MHz clock
    initial begin
        forever #20 clock = ~clock;
    end

    // ************************************
    // Shared tasks
    // ************************************
    // Verdict and end of run, the only exit
    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compare with case equality so unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sync reset pulse of n cycles
    task automatic rst(input int n);
        @(posedge clock);
        srst <= 1'b1;
        repeat (n) @(posedge clock);
        srst <= 1'b0;
    endtask

    // One word, offered only once fetch is ready; results read at a falling edge
    task automatic exec(input logic [9:0] w);
        int i;
        i = 0;
        @(negedge clock);
        while (fetchReady_ff !== 1'b1 && i < 20) begin
            @(negedge clock);
            i++;
        end
        if (i == 20) begin
            num_errors++;
            report_and_stop();
        end
        @(posedge clock);
        instr <= w;
        instrValid <= 1'b1;
        @(posedge clock);
        instrValid <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    // Return address push, optionally with interrupt context
    task automatic push(input logic [11:0] p, input logic sv, input bsr_ctx_s ctx);
        @(posedge clock);
        stackPush <= 1'b1;
        pushPc <= p;
        ctxSave <= sv;
        ctxIn <= ctx;
        @(posedge clock);
        stackPush <= 1'b0;
        ctxSave <= 1'b0;
        @(negedge clock);
    endtask

    // Context built from pointer, accumulator and carry; ptrZ and regB non-zero to see restore
    function automatic bsr_ctx_s mk(input logic [3:0] x, input logic [3:0] y, input logic [3:0] a, input logic c);
        mk = '{ptrX: x, ptrY: y, ptrZ: 2'h2, carry: c, skip: 1'b0, loadSup: 1'b0, accA: a, regB: 4'h5};
    endfunction

    // Load state by interrupt entry save and interrupt return
    task automatic load(input bsr_ctx_s ctx);
        push(12'h3a5, 1'b1, ctx);
        exec(OP_RET_IRQ);
        chk(state_ff, ctx);
        chk(pc_ff, 12'h3a5);
    endtask

    // ************************************
    // Main sequence
    // ************************************
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        // Split so no field falls off the 32-bit compare
        chk({pc_ff, stackLevel_ff, portD_ff, portC_ff, flags_ff}, 32'h0);
        chk(state_ff, 32'h0);
        chk(fetchReady_ff, 1'b0);
        // Fetch opens one cycle after release
        @(negedge clock);
        chk(fetchReady_ff, 1'b1);
        // Table cases; a skipped carry-set word must leave the carry alone
        for (int r = 0; r < NROW; r++) begin
            rst(2);
            irqCtrl1 <= ROWS[r].e1;
            irqCtrl2 <= ROWS[r].e2;
            intCtrl1 <= ROWS[r].i1;
            powerDown <= ROWS[r].pd;
            irqPin <= ROWS[r].pin;
            portCIn <= ROWS[r].pcIn;
            load(mk(4'h0, 4'h0, ROWS[r].a, ROWS[r].c));
            @(posedge clock);
            flagSet <= ROWS[r].fs;
            @(posedge clock);
            flagSet <= 4'h0;
            exec(ROWS[r].op);
            chk(state_ff.accA, ROWS[r].xa);
            chk(state_ff.carry, ROWS[r].xc);
            chk(state_ff.skip, ROWS[r].xs);
            chk(flags_ff, ROWS[r].xf);
            exec(OP_CARRY_SET);
            chk(state_ff.carry, ROWS[r].xs ? ROWS[r].xc : 1'b1);
        end
        // Port D index inside and outside the six bits
        rst(2);
        for (int k = 0; k < 5; k++) begin
            load(mk(4'h0, PD_Y[k], 4'h0, 1'b0));
            exec(PD_OP[k]);
            chk(portD_ff, PD_EXP[k]);
        end
        exec(OP_PORTC_SET);
        chk(portC_ff, 1'b1);
        exec(OP_PORTC_CLR);
        chk(portC_ff, 1'b0);
        // Nibble built bit by bit, then probed by compare and bit tests
        load(mk(4'h1, 4'h2, 4'ha, 1'b0));
        for (int j = 0; j < 4; j++) begin
            exec({OPF_BIT_CLR, 2'(j)});
        end
        exec({OPF_BIT_SET, 2'h1});
        exec({OPF_BIT_SET, 2'h3});
        exec(OP_CMP_MEM);
        chk(state_ff.skip, 1'b1);
        exec(OP_CARRY_CLR);
        for (int j = 0; j < 4; j++) begin
            exec({OPF_BIT_TEST, 2'(j)});
            chk(state_ff.skip, j[0] == 1'b0);
            exec(OP_CARRY_CLR);
        end
        load(mk(4'h1, 4'h2, 4'h5, 1'b0));
        exec(OP_CMP_MEM);
        chk(state_ff.skip, 1'b0);
        // Two-word compare, equal then unequal
        load(mk(4'h0, 4'h0, 4'h7, 1'b0));
        for (int n = 7; n >= 6; n--) begin
            exec(OP_CMP_IMM);
            exec({OPF_CMP_WORD2, 4'(n)});
            chk(state_ff.skip, n == 7);
            exec(OP_CARRY_CLR);
        end
        // Nested returns, the second one skipping
        rst(2);
        push(12'h123, 1'b0, '0);
        push(12'h456, 1'b0, '0);
        chk(stackLevel_ff, 3'h2);
        exec(OP_RET);
        chk({pc_ff, stackLevel_ff}, {12'h456, 3'h1});
        exec(OP_RET_SKIP);
        chk({pc_ff, stackLevel_ff, state_ff.skip}, {12'h123, 3'h0, 1'b1});
        report_and_stop();
    end
endmodule
